/* File: chip_select_defs.svh */
`ifndef CHIP_SELECT_DEFS_SVH
`define CHIP_SELECT_DEFS_SVH

// Register offsets; the four registers form one contiguous block.
`define STRETCH_REG_OFS 16'h105C
`define CONTROL_REG_OFS 16'h105D
`define BASE_REG_OFS 16'h105E
`define SIZE_TIMING_REG_OFS 16'h105F

// Reset values.
`define STRETCH_RST 8'h00
`define STRETCH_RST_EXP 8'h01
`define CONTROL_RST 8'h00
`define CONTROL_RST_EXP 8'h04
`define BASE_RST 8'h00
`define SIZE_TIMING_RST 8'h07

// Field positions in the stretch register.
`define IO_ONE_STRETCH_POS 6
`define IO_TWO_STRETCH_POS 4
`define GENERAL_STRETCH_POS 2
`define PROGRAM_STRETCH_POS 0

// Field positions in the control register.
`define IO_ONE_ENABLE_POS 7
`define IO_ONE_POLARITY_POS 6
`define IO_TWO_ENABLE_POS 5
`define IO_TWO_POLARITY_POS 4
`define PRIORITY_POS 3
`define PROGRAM_ENABLE_POS 2
`define PROGRAM_SIZE_POS 0

// Field positions in the size and timing register.
`define IO_ONE_TIMING_POS 7
`define IO_TWO_TIMING_POS 6
`define GENERAL_POLARITY_POS 4
`define GENERAL_TIMING_POS 3
`define GENERAL_SIZE_POS 0

// Writable bits of the base and size registers.
`define BASE_MASK 8'hFC
`define SIZE_TIMING_MASK 8'hDF

// I/O windows inside the register page.
`define IO_ONE_LOW 12'h060
`define IO_TWO_LOW 12'h800

`endif

/* File: chip_select_pkg.sv */
package chip_select_pkg;

   typedef enum logic [2:0] {
      GSIZE_64K, GSIZE_32K, GSIZE_16K, GSIZE_8K,
      GSIZE_4K, GSIZE_2K, GSIZE_1K, GSIZE_OFF
   } general_size_t;

   typedef enum logic [1:0] {
      PSIZE_64K, PSIZE_32K, PSIZE_16K, PSIZE_8K
   } program_size_t;

   typedef enum {
      BUS_IDLE, BUS_ACCESS, BUS_STRETCH
   } bus_state_t;

endpackage

/* File: chip_select_decoder.sv */
`timescale 1ns/1ps
`include "chip_select_defs.svh"

module chip_select_decoder #(
   parameter int ADDR_WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic expanded_mode,
   input wire logic [3:0] register_page,
   input wire logic [ADDR_WIDTH-1:0] cpu_addr,
   input wire logic cpu_access,
   input wire logic bus_clock_high,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   output logic io_select_one,
   output logic io_select_two,
   output logic program_select,
   output logic general_select,
   output logic io_one_pin_owned,
   output logic io_two_pin_owned,
   output logic program_pin_owned,
   output logic general_pin_owned,
   output logic bus_stretch,
   output logic [1:0] stretch_count
);

   // Configuration registers.
   logic [7:0] select_stretch_register;
   logic [7:0] select_control_register;
   logic [7:0] general_select_base_address;
   logic [7:0] general_select_size_timing;
   logic mode_captured;

   // Shadow copies used by the decoders; they change only between bus cycles.
   logic [7:0] active_stretch;
   logic [7:0] active_control;
   logic [7:0] active_base;
   logic [7:0] active_size;

   chip_select_pkg::bus_state_t state;
   chip_select_pkg::bus_state_t next_state;
   logic [1:0] stretch_left;
   logic [1:0] next_stretch_left;

   // Turns a general size code into the mask of compared base bits 15..10.
   function automatic logic [5:0] general_mask(input logic [2:0] code);
      logic [5:0] mask;
      mask = 6'h00;
      unique case (chip_select_pkg::general_size_t'(code))
         chip_select_pkg::GSIZE_64K: mask = 6'h00;
         chip_select_pkg::GSIZE_32K: mask = 6'h20;
         chip_select_pkg::GSIZE_16K: mask = 6'h30;
         chip_select_pkg::GSIZE_8K: mask = 6'h38;
         chip_select_pkg::GSIZE_4K: mask = 6'h3C;
         chip_select_pkg::GSIZE_2K: mask = 6'h3E;
         chip_select_pkg::GSIZE_1K: mask = 6'h3F;
         chip_select_pkg::GSIZE_OFF: mask = 6'h00;
      endcase
      return mask;
   endfunction

   // Turns a program size code into the mask of address bits 15..13 that must be set.
   function automatic logic [2:0] program_mask(input logic [1:0] code);
      logic [2:0] mask;
      mask = 3'h0;
      unique case (chip_select_pkg::program_size_t'(code))
         chip_select_pkg::PSIZE_64K: mask = 3'h0;
         chip_select_pkg::PSIZE_32K: mask = 3'h4;
         chip_select_pkg::PSIZE_16K: mask = 3'h6;
         chip_select_pkg::PSIZE_8K: mask = 3'h7;
      endcase
      return mask;
   endfunction

   // Drives a select at its active level when hit inside its timing window, otherwise at the inactive one.
   function automatic logic drive_level(input logic active, input logic polarity);
      return active ~^ polarity;
   endfunction

   // Passes a stretch field on only for a select that the access hits.
   function automatic logic [1:0] stretch_pick(input logic hit, input logic [1:0] field);
      return hit ? field : 2'h0;
   endfunction

   // Larger of two requests, so overlapping selects wait for the slowest device.
   function automatic logic [1:0] stretch_max(input logic [1:0] a, input logic [1:0] b);
      return (a > b) ? a : b;
   endfunction

   // Register decode.
   wire hit_stretch = reg_addr == `STRETCH_REG_OFS;
   wire hit_control = reg_addr == `CONTROL_REG_OFS;
   wire hit_base = reg_addr == `BASE_REG_OFS;
   wire hit_size = reg_addr == `SIZE_TIMING_REG_OFS;
   wire [7:0] read_mux = hit_stretch ? select_stretch_register :
                         hit_control ? select_control_register :
                         hit_base ? general_select_base_address :
                         hit_size ? general_select_size_timing : 8'h00;

   // Field extraction from the shadow copies.
   wire io_one_enable_bit = active_control[`IO_ONE_ENABLE_POS];
   wire io_two_enable_bit = active_control[`IO_TWO_ENABLE_POS];
   wire io_one_polarity_bit = active_control[`IO_ONE_POLARITY_POS];
   wire io_two_polarity_bit = active_control[`IO_TWO_POLARITY_POS];
   wire select_priority_bit = active_control[`PRIORITY_POS];
   wire program_enable_bit = active_control[`PROGRAM_ENABLE_POS];
   wire [1:0] program_size_field = active_control[`PROGRAM_SIZE_POS +: 2];
   wire io_one_timing_bit = active_size[`IO_ONE_TIMING_POS];
   wire io_two_timing_bit = active_size[`IO_TWO_TIMING_POS];
   wire general_polarity_bit = active_size[`GENERAL_POLARITY_POS];
   wire general_timing_bit = active_size[`GENERAL_TIMING_POS];
   wire [2:0] general_size_field = active_size[`GENERAL_SIZE_POS +: 3];
   wire [5:0] general_base_bits = active_base[7:2];
   wire [1:0] io_one_stretch_field = active_stretch[`IO_ONE_STRETCH_POS +: 2];
   wire [1:0] io_two_stretch_field = active_stretch[`IO_TWO_STRETCH_POS +: 2];
   wire [1:0] general_stretch_field = active_stretch[`GENERAL_STRETCH_POS +: 2];
   wire [1:0] program_stretch_field = active_stretch[`PROGRAM_STRETCH_POS +: 2];

   // Address decode.
   wire [15:0] addr16 = cpu_addr[15:0];
   wire in_page = addr16[15:12] == register_page;
   wire io_one_range = in_page && addr16[11:0] >= `IO_ONE_LOW && addr16[11:0] < `IO_TWO_LOW;
   wire io_two_range = in_page && addr16[11:0] >= `IO_TWO_LOW;
   wire [5:0] gmask = general_mask(general_size_field);
   wire general_on = general_size_field !=
      3'(chip_select_pkg::GSIZE_OFF);
   wire general_range = general_on &&
      ((addr16[15:10] & gmask) == (general_base_bits & gmask));
   wire [2:0] pmask = program_mask(program_size_field);
   wire program_range = (addr16[15:13] & pmask) == pmask;

   wire io_one_hit = cpu_access && io_one_enable_bit && io_one_range;
   wire io_two_hit = cpu_access && io_two_enable_bit && io_two_range;
   wire general_raw = cpu_access && general_range;
   wire program_raw = cpu_access && program_enable_bit && program_range;
   wire general_hit = general_raw && (select_priority_bit || !program_raw);
   wire program_hit = program_raw && !(select_priority_bit && general_raw);

   // Timing windows: address valid spans the access, clock-high only its high phase.
   wire io_one_window = io_one_timing_bit || bus_clock_high;
   wire io_two_window = io_two_timing_bit || bus_clock_high;
   wire general_window = general_timing_bit || bus_clock_high;

   wire io_one_active = io_one_hit && io_one_window;
   wire io_two_active = io_two_hit && io_two_window;
   wire general_active = general_hit && general_window;
   wire program_active = program_hit;

   // Stretch requested by whichever select the access hits; overlaps take the longest.
   wire [1:0] s1 = stretch_pick(io_one_hit, io_one_stretch_field);
   wire [1:0] s2 = stretch_pick(io_two_hit, io_two_stretch_field);
   wire [1:0] s3 = stretch_pick(general_hit, general_stretch_field);
   wire [1:0] s4 = stretch_pick(program_hit, program_stretch_field);
   wire [1:0] m12 = stretch_max(s1, s2);
   wire [1:0] m34 = stretch_max(s3, s4);
   wire [1:0] hit_stretch_cnt = stretch_max(m12, m34);

   // Bus-cycle sequencer, so configuration only moves between accesses.
   always_comb begin
      next_state = state;
      next_stretch_left = stretch_left;
      unique case (state)
         chip_select_pkg::BUS_IDLE: begin
            if (cpu_access) begin
               next_state = chip_select_pkg::BUS_ACCESS;
               next_stretch_left = hit_stretch_cnt;
            end
         end
         chip_select_pkg::BUS_ACCESS: begin
            if (!cpu_access) begin
               next_state = (stretch_left != 2'h0) ?
                  chip_select_pkg::BUS_STRETCH : chip_select_pkg::BUS_IDLE;
            end
         end
         chip_select_pkg::BUS_STRETCH: begin
            if (!bus_clock_high && stretch_left != 2'h0) begin
               next_stretch_left = stretch_left - 2'h1;
            end
            if (stretch_left == 2'h0) begin
               next_state = chip_select_pkg::BUS_IDLE;
            end
         end
      endcase
   end

   wire between_cycles = state == chip_select_pkg::BUS_IDLE && !cpu_access;

   // The mode strap is caught once, on the first clock after reset.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_captured <= 1'b0;
      end else begin
         mode_captured <= 1'b1;
      end
   end

   // A write on the capture clock is lost, so software waits one clock after reset.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         select_stretch_register <= `STRETCH_RST;
      end else if (!mode_captured) begin
         select_stretch_register <= expanded_mode ? `STRETCH_RST_EXP : `STRETCH_RST;
      end else if (reg_write && hit_stretch) begin
         select_stretch_register <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         select_control_register <= `CONTROL_RST;
      end else if (!mode_captured) begin
         select_control_register <= expanded_mode ? `CONTROL_RST_EXP : `CONTROL_RST;
      end else if (reg_write && hit_control) begin
         select_control_register <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         general_select_base_address <= `BASE_RST;
      end else if (mode_captured && reg_write && hit_base) begin
         general_select_base_address <= reg_wdata & `BASE_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         general_select_size_timing <= `SIZE_TIMING_RST;
      end else if (mode_captured && reg_write && hit_size) begin
         general_select_size_timing <= reg_wdata & `SIZE_TIMING_MASK;
      end
   end

   // Shadows load only while no bus cycle runs, so a select never changes mid-cycle.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_stretch <= `STRETCH_RST;
      end else if (between_cycles) begin
         active_stretch <= select_stretch_register;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_control <= `CONTROL_RST;
      end else if (between_cycles) begin
         active_control <= select_control_register;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_base <= `BASE_RST;
      end else if (between_cycles) begin
         active_base <= general_select_base_address;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_size <= `SIZE_TIMING_RST;
      end else if (between_cycles) begin
         active_size <= general_select_size_timing;
      end
   end

   // Sequencer state and the stretch countdown.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= chip_select_pkg::BUS_IDLE;
         stretch_left <= 2'h0;
      end else begin
         state <= next_state;
         stretch_left <= next_stretch_left;
      end
   end

   // Read data stand for one cycle after a read and are zero otherwise.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_read ? read_mux : 8'h00;
      end
   end

   // Selects reset to 1, which is inactive because every polarity bit clears at reset.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         io_select_one <= 1'b1;
      end else begin
         io_select_one <= drive_level(io_one_active, io_one_polarity_bit);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         io_select_two <= 1'b1;
      end else begin
         io_select_two <= drive_level(io_two_active, io_two_polarity_bit);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         program_select <= 1'b1;
      end else begin
         program_select <= !program_active;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         general_select <= 1'b1;
      end else begin
         general_select <= drive_level(general_active, general_polarity_bit);
      end
   end

   // Pin ownership follows the enables that the decoders currently use.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         io_one_pin_owned <= 1'b0;
         io_two_pin_owned <= 1'b0;
         program_pin_owned <= 1'b0;
         general_pin_owned <= 1'b0;
      end else begin
         io_one_pin_owned <= io_one_enable_bit;
         io_two_pin_owned <= io_two_enable_bit;
         program_pin_owned <= program_enable_bit;
         general_pin_owned <= general_on;
      end
   end

   // Stretch outputs show the next state so that they line up with the selects.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_stretch <= 1'b0;
         stretch_count <= 2'h0;
      end else begin
         bus_stretch <= next_state == chip_select_pkg::BUS_STRETCH;
         stretch_count <= next_stretch_left;
      end
   end

endmodule // chip_select_decoder

/* File: chip_select_props.sv */
`timescale 1ns/1ps
`include "chip_select_defs.svh"
module chip_select_props #(
   parameter int ADDR_WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic expanded_mode,
   input wire logic [3:0] register_page,
   input wire logic [ADDR_WIDTH-1:0] cpu_addr,
   input wire logic cpu_access,
   input wire logic bus_clock_high,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic io_select_one,
   input wire logic io_select_two,
   input wire logic program_select,
   input wire logic general_select,
   input wire logic io_one_pin_owned,
   input wire logic io_two_pin_owned,
   input wire logic program_pin_owned,
   input wire logic general_pin_owned,
   input wire logic bus_stretch,
   input wire logic [1:0] stretch_count
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   sequence size_wr_rd;
      reg_write && reg_addr == `SIZE_TIMING_REG_OFS ##1 reg_read && reg_addr == `SIZE_TIMING_REG_OFS;
   endsequence
   sequence base_wr_rd;
      reg_write && reg_addr == `BASE_REG_OFS ##1 reg_read && reg_addr == `BASE_REG_OFS;
   endsequence
   a_size_readback: assert property (size_wr_rd |=>
      reg_rdata == ($past(reg_wdata, 2) & `SIZE_TIMING_MASK)) else $error("size read-back wrong");
   a_base_readback: assert property (base_wr_rd |=>
      reg_rdata == ($past(reg_wdata, 2) & `BASE_MASK)) else $error("base read-back wrong");
   a_unmapped_zero: assert property (reg_read && (reg_addr < `STRETCH_REG_OFS ||
      reg_addr > `SIZE_TIMING_REG_OFS) |=> reg_rdata == 8'h00) else $error("unmapped read not 0");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data without read");
   a_base_low_bits: assert property (reg_read && reg_addr == `BASE_REG_OFS |=>
      reg_rdata[1:0] == 2'h0) else $error("base low bits not 0");
   a_size_bit_five: assert property (reg_read && reg_addr == `SIZE_TIMING_REG_OFS |=>
      reg_rdata[5] == 1'b0) else $error("size bit 5 not 0");
   a_prog_idle_high: assert property (!$past(cpu_access) && !$past(bus_stretch) |->
      program_select) else $error("program select active outside access");
   a_stretch_ends: assert property ($rose(bus_stretch) |-> ##[1:20] !bus_stretch)
      else $error("stretch too long");
endmodule // chip_select_props

bind chip_select_decoder chip_select_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (.core_clk, .arst_n,
   .expanded_mode, .register_page, .cpu_addr, .cpu_access, .bus_clock_high, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .io_select_one, .io_select_two, .program_select,
   .general_select, .io_one_pin_owned, .io_two_pin_owned, .program_pin_owned, .general_pin_owned,
   .bus_stretch, .stretch_count);

/* File: chip_select_bus_partner.sv */
`timescale 1ns/1ps
module chip_select_bus_partner (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [1:0] e_mode,
   output logic bus_clock_high
);
   // Toggling every cycle lets a stretch of n bus clocks finish in about 2n core cycles.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_clock_high <= 1'b0;
      end else if (e_mode == 2'h2) begin
         bus_clock_high <= !bus_clock_high;
      end else begin
         bus_clock_high <= e_mode[0];
      end
   end
endmodule // chip_select_bus_partner

/* File: chip_select_decoder_bench.sv */
`timescale 1ns/1ps
`include "chip_select_defs.svh"
module chip_select_decoder_bench;
   logic core_clk, arst_n, expanded_mode, cpu_access, reg_write, reg_read, bus_clock_high;
   logic io_select_one, io_select_two, program_select, general_select, bus_stretch, saw_str;
   logic io_one_pin_owned, io_two_pin_owned, program_pin_owned, general_pin_owned;
   logic [1:0] stretch_count, e_mode, sc;
   logic [3:0] register_page, sel;
   logic [15:0] cpu_addr, reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d;
   int error_cnt, num_checks, cycles;
   chip_select_decoder #(.ADDR_WIDTH(16)) i_dut (.core_clk, .arst_n, .expanded_mode,
      .register_page, .cpu_addr, .cpu_access, .bus_clock_high, .reg_addr, .reg_wdata, .reg_write,
      .reg_read, .reg_rdata, .io_select_one, .io_select_two, .program_select, .general_select,
      .io_one_pin_owned, .io_two_pin_owned, .program_pin_owned, .general_pin_owned,
      .bus_stretch, .stretch_count);
   chip_select_bus_partner i_bus (.core_clk, .arst_n, .e_mode, .bus_clock_high);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 8000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic op(input logic w, input logic r, input logic [15:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_write <= w;
      reg_read <= r;
      reg_addr <= a;
      reg_wdata <= v;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      op(1'b1, 1'b0, a, v);
      op(1'b0, 1'b0, a, v);
   endtask
   // Write and read back with no gap; the read returns the masked value just written.
   task automatic rd(input logic [15:0] a, input logic w, input logic [7:0] v);
      if (w) op(1'b1, 1'b0, a, v);
      op(1'b0, 1'b1, a, 8'h00);
      op(1'b0, 1'b0, a, 8'h00);
      @(negedge core_clk);
      d = reg_rdata;
   endtask
   task automatic acc(input logic [15:0] a, input logic [1:0] e);
      @(posedge core_clk);
      cpu_addr <= a;
      cpu_access <= 1'b1;
      e_mode <= e;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      sel = {io_select_one, io_select_two, program_select, general_select};
      @(posedge core_clk);
      cpu_access <= 1'b0;
      e_mode <= 2'h2;
      saw_str = 1'b0;
      sc = 2'h0;
      repeat (12) @(negedge core_clk) begin
         if (bus_stretch && !saw_str) sc = stretch_count;
         saw_str |= bus_stretch;
      end
   endtask
   task automatic io_case(input logic [15:0] a, input logic e, input logic x1, input logic x2);
      acc(a, {1'b0, e});
      chk1("io_select_one", x1, sel[3]);
      chk1("io_select_two", x2, sel[2]);
   endtask
   task automatic t_reset(input logic mode);
      @(posedge core_clk);
      arst_n <= 1'b0;
      expanded_mode <= mode;
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd(`SIZE_TIMING_REG_OFS, 1'b0, 8'h00);
      chk8("size_timing", `SIZE_TIMING_RST, d);
      rd(`BASE_REG_OFS, 1'b0, 8'h00);
      chk8("base", 8'h00, d);
      rd(`CONTROL_REG_OFS, 1'b0, 8'h00);
      chk8("control", mode ? 8'h04 : 8'h00, d);
      rd(`STRETCH_REG_OFS, 1'b0, 8'h00);
      chk8("stretch", mode ? 8'h01 : 8'h00, d);
      rd(16'h1060, 1'b1, 8'h5A);
      chk8("unmapped", 8'h00, d);
      chk1("program_pin_owned", mode, program_pin_owned);
      acc(16'hFFFF, 2'h1);
      chk1("program_select", !mode, sel[1]);
      $display("test reset done");
   endtask
   task automatic t_io();
      rd(`BASE_REG_OFS, 1'b1, 8'hFF);
      chk8("base", 8'hFC, d);
      rd(`SIZE_TIMING_REG_OFS, 1'b1, 8'hFF);
      chk8("size_timing", 8'hDF, d);
      @(posedge core_clk);
      register_page <= 4'hA;
      wr(`CONTROL_REG_OFS, 8'hE4);
      wr(`SIZE_TIMING_REG_OFS, 8'h87);
      io_case(16'hA060, 1'b0, 1'b1, 1'b1);
      io_case(16'hA05F, 1'b1, 1'b0, 1'b1);
      io_case(16'hA7FF, 1'b1, 1'b1, 1'b1);
      io_case(16'hA800, 1'b1, 1'b0, 1'b0);
      io_case(16'hAFFF, 1'b0, 1'b0, 1'b1);
      io_case(16'hB800, 1'b1, 1'b0, 1'b1);
      wr(`STRETCH_REG_OFS, 8'h20);
      io_case(16'hA800, 1'b1, 1'b0, 1'b0);
      chk8("stretch_count", 8'h02, {6'h00, sc});
      chk1("io_two_pin_owned", 1'b1, io_two_pin_owned);
      wr(`CONTROL_REG_OFS, 8'h04);
      io_case(16'hA800, 1'b1, 1'b1, 1'b1);
      chk1("io_one_pin_owned", 1'b0, io_one_pin_owned);
      $display("test io done");
   endtask
   task automatic t_gen();
      logic [16:0] sz;
      logic [15:0] start;
      wr(`CONTROL_REG_OFS, 8'h0C);
      for (int c = 0; c < 8; c++) begin
         sz = 17'h10000 >> c;
         start = 16'hFC00 & ~(sz[15:0] - 16'h0001);
         wr(`SIZE_TIMING_REG_OFS, 8'h18 | 8'(c));
         acc(start, 2'h0);
         chk1("general_select", c != 7, sel[0]);
         chk1("program_select", c != 7, sel[1]);
         chk1("general_pin_owned", c != 7, general_pin_owned);
         if (c != 0) acc(start - 16'h0001, 2'h1);
         chk1("general_select", c == 0, sel[0]);
      end
      wr(`STRETCH_REG_OFS, 8'h0C);
      wr(`SIZE_TIMING_REG_OFS, 8'h06);
      acc(16'hFC00, 2'h1);
      chk1("general_select", 1'b0, sel[0]);
      chk1("bus_stretch", 1'b1, saw_str);
      chk8("stretch_count", 8'h03, {6'h00, sc});
      acc(16'hFC00, 2'h0);
      chk1("general_select", 1'b1, sel[0]);
      $display("test general done");
   endtask
   task automatic t_prog();
      logic [16:0] start;
      wr(`SIZE_TIMING_REG_OFS, 8'h07);
      wr(`STRETCH_REG_OFS, 8'h00);
      for (int c = 0; c < 4; c++) begin
         start = 17'h10000 - (17'h10000 >> c);
         wr(`CONTROL_REG_OFS, 8'h04 | 8'(c));
         acc(start[15:0], 2'h0);
         chk1("program_select", 1'b0, sel[1]);
         chk1("bus_stretch", 1'b0, saw_str);
         chk8("stretch_count", 8'h00, {6'h00, sc});
         if (c != 0) acc(start[15:0] - 16'h0001, 2'h1);
         chk1("program_select", c == 0 ? 1'b0 : 1'b1, sel[1]);
      end
      wr(`STRETCH_REG_OFS, 8'h03);
      wr(`SIZE_TIMING_REG_OFS, 8'h1E);
      acc(16'hFC00, 2'h1);
      chk1("program_select", 1'b0, sel[1]);
      chk1("general_select", 1'b0, sel[0]);
      chk1("bus_stretch", 1'b1, saw_str);
      chk8("stretch_count", 8'h03, {6'h00, sc});
      wr(`CONTROL_REG_OFS, 8'h0F);
      acc(16'hFC00, 2'h1);
      chk1("program_select", 1'b1, sel[1]);
      chk1("general_select", 1'b1, sel[0]);
      $display("test program done");
   endtask
   initial begin
      {arst_n, expanded_mode, cpu_access, reg_write, reg_read} = 5'h00;
      {register_page, cpu_addr, reg_addr, reg_wdata} = 44'h0;
      e_mode = 2'h2;
      t_reset(1'b1);
      t_io();
      t_gen();
      t_prog();
      t_reset(1'b0);
      end_of_test();
   end
endmodule // chip_select_decoder_bench
